// *** bwss_pkg.sv ***
// Package for the bridge window and secondary status register bank
package bwss_pkg;
	// Register word byte addresses
	localparam logic [7:0] IO_STATUS_ADDR   = 8'h1c;
	localparam logic [7:0] MEM_WINDOW_ADDR  = 8'h20;
	localparam logic [7:0] IO_UPPER_ADDR    = 8'h30;
	localparam logic [7:0] CONTROL_ADDR     = 8'h40;
	localparam logic [7:0] IRQ_MASK_ADDR    = 8'h44;

	// Field positions in the word at 0x1c
	localparam int IO_BASE_LSB   = 4;
	localparam int IO_CAP_LSB    = 8;
	localparam int IO_TOP_LSB    = 12;
	localparam int PAR_BIT       = 24;
	localparam int STA_BIT       = 27;
	localparam int RTA_BIT       = 28;
	localparam int RMA_BIT       = 29;
	localparam int SERR_BIT      = 30;
	localparam int POIS_BIT      = 31;

	// Field positions in the word at 0x20
	localparam int MEM_BASE_LSB  = 4;
	localparam int MEM_TOP_LSB   = 20;

	// Field positions in the control word
	localparam int PER_EN_BIT    = 0;
	localparam int SERR_EN_BIT   = 1;

	// Constant and reset values
	localparam logic [3:0]  IO_ADDR_CAP   = 4'h1;
	localparam logic [3:0]  IO_FIELD_RST  = 4'h0;
	localparam logic [11:0] MEM_FIELD_RST = 12'h000;
	localparam logic [15:0] IO_UPPER_RST  = 16'h0000;
	localparam logic [11:0] IO_LOW_ONES   = 12'hfff;
	localparam logic [11:0] IO_LOW_ZERO   = 12'h000;
	localparam logic [19:0] MEM_LOW_ONES  = 20'hf_ffff;
	localparam logic [19:0] MEM_LOW_ZERO  = 20'h0_0000;
	localparam logic [5:0]  FLAGS_RST     = 6'h00;

	// Error events from the transaction layer, one cycle each
	typedef struct packed {
		logic poisoned_rx;     // Poisoned packet received downstream
		logic err_msg_sent;    // Fatal or nonfatal message sent
		logic rx_ur_cpl;       // Unsupported request completion received
		logic rx_ca_cpl;       // Completer abort completion received
		logic tx_ca_cpl;       // Completed a request with completer abort
		logic parity_err;      // Parity error detected or forwarded
	} bwss_event_type;

	// Window compare request and answer
	typedef struct packed {
		logic [31:0] addr;     // Address under test
	} bwss_probe_type;

	typedef struct packed {
		logic io_hit;          // Address inside the I/O window
		logic mem_hit;         // Address inside the memory window
	} bwss_hit_type;
endpackage

// *** bwss_top.sv ***
// Bridge window limits, downstream status flags and window compare
// Notes on behaviour
// R1: I/O capability field reads constant 1h.
// R2: I/O top bits 15:12 writable, low ones.
// R3: I/O top 31:16 from upper-half register.
// R4: I/O top address decides I/O forwarding.
// R5: Legacy status bits read zero always.
// R6: Parity error sets bit 24, W1C.
// R7: No parity flag while response disabled.
// R8: Completer abort sent sets bit 27.
// R9: Completer abort received sets bit 28.
// R10: Unsupported request received sets bit 29.
// R11: Error message with enable sets bit 30.
// R12: Poisoned packet received sets bit 31.
// R13: Memory bottom bits 31:20 writable, low zero.
// R14: Memory bottom decides memory forwarding.
// R15: Memory top low bits all ones.
// R16: I/O bottom low bits zero.
// R17: Inclusive window compare; reserved reads zero.
// R18: Write one clears; zero leaves flag. Flags 27..29 here ignore writes and clear only on reset.
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
module bwss_top (
	input  wire logic                    clk,
	input  wire logic                    rstn,
	input  wire logic                    wb_cyc_i,
	input  wire logic                    wb_stb_i,
	input  wire logic                    wb_we_i,
	input  wire logic [7:0]              wb_adr_i,
	input  wire logic [3:0]              wb_sel_i,
	input  wire logic [31:0]             wb_dat_i,
	output logic      [31:0]             wb_dat_o,
	output logic                         wb_ack_o,
	input  wire bwss_pkg::bwss_event_type events,
	input  wire bwss_pkg::bwss_probe_type probe,
	output bwss_pkg::bwss_hit_type       hits,
	output logic                         irq
);
	// Register map, one 32-bit word per offset:
	//   0x1c [7:4] I/O bottom 15:12, [11:8] capability, [15:12] I/O top 15:12,
	//        [24] parity W1C, [27..29] read-only sticky, [30] system error W1C,
	//        [31] poison W1C; every other bit reads zero
	//   0x20 [15:4] memory bottom 31:20, [31:20] memory top 31:20
	//   0x30 [15:0] I/O bottom 31:16, [31:16] I/O top 31:16
	//   0x40 [0] parity error response enable, [1] system_error_report_enable
	//   0x44 interrupt mask in the same bit places as the 0x1c flags
	// The 27..29 flags clear only on reset, so an abort seen once keeps the
	// interrupt up while unmasked; software has to mask it.
	// Multi-byte fields update only when all their lanes are selected, which
	// keeps a field from holding a half-old, half-new window edge.
	// Writable fields
	logic [3:0]  io_base_r, io_base_nxt;        // I/O bottom 15:12
	logic [3:0]  io_top_r, io_top_nxt;          // I/O top 15:12
	logic [15:0] io_base_up_r, io_base_up_nxt;  // I/O bottom 31:16
	logic [15:0] io_top_up_r, io_top_up_nxt;    // I/O top 31:16
	logic [11:0] mem_base_r, mem_base_nxt;      // Memory bottom 31:20
	logic [11:0] mem_top_r, mem_top_nxt;        // Memory top 31:20
	logic        per_en_r, per_en_nxt;          // Parity error response enable
	logic        serr_en_r, serr_en_nxt;        // System error report enable
	logic [5:0]  flags_r, flags_nxt;            // Sticky status, 24 and 27..31
	logic [5:0]  mask_r, mask_nxt;              // Interrupt mask, same layout
	logic        ack_r, ack_nxt;                // Bus acknowledge
	logic [31:0] rdat_r, rdat_nxt;              // Read data
	bwss_pkg::bwss_hit_type hits_r, hits_nxt;   // Registered compare answer

	// Bus decode helpers
	logic        req;
	logic        wr;
	logic [31:0] bmask;
	logic [31:0] wv;
	logic [5:0]  set_v;
	logic [5:0]  clr_v;
	logic [31:0] word_1c;
	logic [31:0] word_20;
	logic [31:0] word_44;      // Mask read view, status layout
	logic [31:0] io_lo;        // I/O window bottom, low bits zero
	logic [31:0] io_hi;        // I/O window top, low bits ones
	logic [31:0] mem_lo;       // Memory window bottom
	logic [31:0] mem_hi;       // Memory window top

	// New request only when no ack is pending, so each cycle acks once
	assign req = wb_cyc_i && wb_stb_i && !ack_r;
	assign wr  = req && wb_we_i;
	assign bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wv = wb_dat_i & bmask;

	// Enables are registered, so an event in the cycle of the enable
	// write still sees the old enable.
	// Event vector in flag order: bit0=24, bits1..5=27..31
	always_comb begin
		set_v = {events.poisoned_rx,
			events.err_msg_sent && serr_en_r,             // R11
			events.rx_ur_cpl,                              // R10
			events.rx_ca_cpl,                              // R9
			events.tx_ca_cpl,                              // R8
			events.parity_err && per_en_r};                // R6 R7
		// Only the write-one-clear flags take clears; 27..29 ignore writes
		clr_v = '0;
		if (wr && wb_adr_i == bwss_pkg::IO_STATUS_ADDR) begin
			clr_v[0] = wv[bwss_pkg::PAR_BIT];              // R18
			clr_v[4] = wv[bwss_pkg::SERR_BIT];             // R18
			clr_v[5] = wv[bwss_pkg::POIS_BIT];             // R12
		end
	end

	// Views are built every cycle; a read picks one by address
	// Read views; unlisted bits including legacy ones stay zero
	always_comb begin
		word_1c = '0;                                      // R5 R17
		word_1c[bwss_pkg::IO_BASE_LSB +: 4] = io_base_r;
		word_1c[bwss_pkg::IO_CAP_LSB +: 4]  = bwss_pkg::IO_ADDR_CAP; // R1
		word_1c[bwss_pkg::IO_TOP_LSB +: 4]  = io_top_r;
		word_1c[bwss_pkg::PAR_BIT] = flags_r[0];
		word_1c[bwss_pkg::STA_BIT +: 5] = flags_r[5:1];
		word_20 = '0;
		word_20[bwss_pkg::MEM_BASE_LSB +: 12] = mem_base_r;
		word_20[bwss_pkg::MEM_TOP_LSB +: 12]  = mem_top_r;
		word_44 = '0;                                      // Same places as the flags
		word_44[bwss_pkg::PAR_BIT] = mask_r[0];
		word_44[bwss_pkg::STA_BIT +: 5] = mask_r[5:1];
	end

	// One request gives exactly one ack; the !ack_r term in req stops a
	// strobe still high in its ack cycle from being taken a second time.
	// Register writes, flags and bus answer
	always_comb begin
		io_base_nxt    = io_base_r;
		io_top_nxt     = io_top_r;
		io_base_up_nxt = io_base_up_r;
		io_top_up_nxt  = io_top_up_r;
		mem_base_nxt   = mem_base_r;
		mem_top_nxt    = mem_top_r;
		per_en_nxt     = per_en_r;
		serr_en_nxt    = serr_en_r;
		mask_nxt       = mask_r;
		// Set wins over a clear in the same cycle
		flags_nxt      = (flags_r & ~clr_v) | set_v;       // R18
		ack_nxt        = req;
		rdat_nxt       = rdat_r;
		if (wr) begin
			case (wb_adr_i)
				bwss_pkg::IO_STATUS_ADDR: begin
					if (wb_sel_i[0])
						io_base_nxt = wb_dat_i[bwss_pkg::IO_BASE_LSB +: 4];
					if (wb_sel_i[1])
						io_top_nxt = wb_dat_i[bwss_pkg::IO_TOP_LSB +: 4]; // R2
				end
				bwss_pkg::MEM_WINDOW_ADDR: begin
					if (wb_sel_i[1] && wb_sel_i[0])
						mem_base_nxt = wb_dat_i[bwss_pkg::MEM_BASE_LSB +: 12]; // R13
					if (wb_sel_i[3] && wb_sel_i[2])
						mem_top_nxt = wb_dat_i[bwss_pkg::MEM_TOP_LSB +: 12];
				end
				bwss_pkg::IO_UPPER_ADDR: begin
					if (wb_sel_i[1] && wb_sel_i[0])
						io_base_up_nxt = wb_dat_i[15:0];
					if (wb_sel_i[3] && wb_sel_i[2])
						io_top_up_nxt = wb_dat_i[31:16];        // R3
				end
				bwss_pkg::CONTROL_ADDR: begin
					if (wb_sel_i[0]) begin
						per_en_nxt  = wb_dat_i[bwss_pkg::PER_EN_BIT];
						serr_en_nxt = wb_dat_i[bwss_pkg::SERR_EN_BIT];
					end
				end
				bwss_pkg::IRQ_MASK_ADDR: begin
					if (wb_sel_i[3])
						mask_nxt = {wb_dat_i[bwss_pkg::STA_BIT +: 5], wb_dat_i[bwss_pkg::PAR_BIT]};
				end
				default: begin
					// Unmapped writes are acked and dropped
				end
			endcase
		end
		if (req && !wb_we_i) begin
			case (wb_adr_i)
				bwss_pkg::IO_STATUS_ADDR:  rdat_nxt = word_1c;
				bwss_pkg::MEM_WINDOW_ADDR: rdat_nxt = word_20;
				bwss_pkg::IO_UPPER_ADDR:   rdat_nxt = {io_top_up_r, io_base_up_r};
				bwss_pkg::CONTROL_ADDR:    rdat_nxt = {30'h0000_0000, serr_en_r, per_en_r};
				bwss_pkg::IRQ_MASK_ADDR:   rdat_nxt = word_44;
				default:                   rdat_nxt = 32'h0000_0000;
			endcase
		end
	end

	// Registering the answer costs a cycle but keeps the wide compare
	// off the forwarding path's timing.
	// Window bounds and inclusive compare, registered one cycle
	always_comb begin
		io_lo  = {io_base_up_r, io_base_r, bwss_pkg::IO_LOW_ZERO};     // R16
		io_hi  = {io_top_up_r, io_top_r, bwss_pkg::IO_LOW_ONES};       // R2 R3
		mem_lo = {mem_base_r, bwss_pkg::MEM_LOW_ZERO};                 // R13
		mem_hi = {mem_top_r, bwss_pkg::MEM_LOW_ONES};                  // R15
		hits_nxt.io_hit  = (probe.addr >= io_lo) && (probe.addr <= io_hi);   // R4 R17
		hits_nxt.mem_hit = (probe.addr >= mem_lo) && (probe.addr <= mem_hi); // R14 R17
	end

	// Every state bit resets here; there is no asynchronous path,
	// so reset takes effect on the next rising edge.
	// Only registering here, synchronous reset
	always_ff @(posedge clk) begin
		if (!rstn) begin
			io_base_r    <= bwss_pkg::IO_FIELD_RST;
			io_top_r     <= bwss_pkg::IO_FIELD_RST;
			io_base_up_r <= bwss_pkg::IO_UPPER_RST;
			io_top_up_r  <= bwss_pkg::IO_UPPER_RST;
			mem_base_r   <= bwss_pkg::MEM_FIELD_RST;
			mem_top_r    <= bwss_pkg::MEM_FIELD_RST;
			per_en_r     <= 1'b0;
			serr_en_r    <= 1'b0;
			flags_r      <= bwss_pkg::FLAGS_RST;
			mask_r       <= bwss_pkg::FLAGS_RST;
			ack_r        <= 1'b0;
			rdat_r       <= 32'h0000_0000;
			hits_r       <= '0;
		end else begin
			io_base_r    <= io_base_nxt;
			io_top_r     <= io_top_nxt;
			io_base_up_r <= io_base_up_nxt;
			io_top_up_r  <= io_top_up_nxt;
			mem_base_r   <= mem_base_nxt;
			mem_top_r    <= mem_top_nxt;
			per_en_r     <= per_en_nxt;
			serr_en_r    <= serr_en_nxt;
			flags_r      <= flags_nxt;
			mask_r       <= mask_nxt;
			ack_r        <= ack_nxt;
			rdat_r       <= rdat_nxt;
			hits_r       <= hits_nxt;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;
	assign hits     = hits_r;
	// Level interrupt while any unmasked flag stands
	assign irq      = |(flags_r & mask_r);

	// Checks, all on the bus clock with reset held off
	// Bus steps that several properties start from
	sequence s_status_read;
		req && !wb_we_i && wb_adr_i == bwss_pkg::IO_STATUS_ADDR;
	endsequence
	sequence s_mem_read;
		req && !wb_we_i && wb_adr_i == bwss_pkg::MEM_WINDOW_ADDR;
	endsequence
	sequence s_status_write;
		wr && wb_adr_i == bwss_pkg::IO_STATUS_ADDR && wb_sel_i == 4'hf;
	endsequence
	sequence s_mem_write;
		wr && wb_adr_i == bwss_pkg::MEM_WINDOW_ADDR && wb_sel_i == 4'hf;
	endsequence
	sequence s_upper_write;
		wr && wb_adr_i == bwss_pkg::IO_UPPER_ADDR && wb_sel_i == 4'hf;
	endsequence
	chk_cap_const: assert property (@(posedge clk) disable iff (!rstn) // R1
		s_status_read |=> wb_dat_o[bwss_pkg::IO_CAP_LSB +: 4] == bwss_pkg::IO_ADDR_CAP)
		else $error("io capability field not 1h");
	chk_legacy_zero: assert property (@(posedge clk) disable iff (!rstn) // R5
		ack_r && $past(!wb_we_i && wb_adr_i == bwss_pkg::IO_STATUS_ADDR)
		|-> (wb_dat_o[26:25] == 2'b00 && !wb_dat_o[21] && !wb_dat_o[23]))
		else $error("legacy status bits not zero");
	chk_par_block: assert property (@(posedge clk) disable iff (!rstn) // R7
		!per_en_r && !flags_r[0] |=> !flags_r[0])
		else $error("parity flag set while response disabled");
	chk_par_set: assert property (@(posedge clk) disable iff (!rstn) // R6
		events.parity_err && per_en_r |=> flags_r[0])
		else $error("parity flag not set");
	chk_serr_set: assert property (@(posedge clk) disable iff (!rstn) // R11
		events.err_msg_sent |=> (flags_r[4] == ($past(serr_en_r) || $past(flags_r[4]) && !$past(clr_v[4]))))
		else $error("system error flag wrong");
	sequence s_abort_seen;
		events.tx_ca_cpl || events.rx_ca_cpl || events.rx_ur_cpl;
	endsequence
	chk_ro_sticky: assert property (@(posedge clk) disable iff (!rstn) // R8 R9 R10
		s_abort_seen |=> (flags_r[3:1] != 3'b000) ##1 (flags_r[3:1] != 3'b000))
		else $error("read-only abort flag lost");
	chk_w1c_zero: assert property (@(posedge clk) disable iff (!rstn) // R18
		wr && wb_adr_i == bwss_pkg::IO_STATUS_ADDR && !wb_dat_i[bwss_pkg::POIS_BIT] && flags_r[5]
		|=> flags_r[5])
		else $error("zero write cleared poison flag");
	chk_pois_clr: assert property (@(posedge clk) disable iff (!rstn) // R12
		clr_v[5] && !events.poisoned_rx |=> !flags_r[5])
		else $error("poison flag not cleared");
	chk_io_hit: assert property (@(posedge clk) disable iff (!rstn) // R4 R17
		probe.addr == io_hi && io_lo <= io_hi |=> hits.io_hit)
		else $error("io top address not inside window");
	chk_mem_hit: assert property (@(posedge clk) disable iff (!rstn) // R14 R17
		probe.addr == mem_lo && mem_lo <= mem_hi |=> hits.mem_hit)
		else $error("memory bottom not inside window");
	chk_ack_once: assert property (@(posedge clk) disable iff (!rstn)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	// Bus answer timing
	chk_ack_next: assert property (@(posedge clk) disable iff (!rstn)
		req |=> wb_ack_o)
		else $error("request not acked next cycle");
	chk_ack_idle: assert property (@(posedge clk) disable iff (!rstn)
		!req |=> !wb_ack_o)
		else $error("ack without request");
	// Reserved bits read zero
	chk_rsvd_status: assert property (@(posedge clk) disable iff (!rstn) // R5 R17
		s_status_read |=> (wb_dat_o[3:0] == 4'h0 && wb_dat_o[22:16] == 7'h00))
		else $error("status reserved bits not zero");
	chk_rsvd_mem: assert property (@(posedge clk) disable iff (!rstn) // R17
		s_mem_read |=> (wb_dat_o[3:0] == 4'h0 && wb_dat_o[19:16] == 4'h0))
		else $error("memory reserved bits not zero");
	// Full-lane field writes land
	chk_io_top_wr: assert property (@(posedge clk) disable iff (!rstn) // R2
		s_status_write |=> io_top_r == $past(wb_dat_i[bwss_pkg::IO_TOP_LSB +: 4]))
		else $error("io top field not written");
	chk_io_base_wr: assert property (@(posedge clk) disable iff (!rstn) // R16
		s_status_write |=> io_base_r == $past(wb_dat_i[bwss_pkg::IO_BASE_LSB +: 4]))
		else $error("io bottom field not written");
	chk_mem_base_wr: assert property (@(posedge clk) disable iff (!rstn) // R13
		s_mem_write |=> mem_base_r == $past(wb_dat_i[bwss_pkg::MEM_BASE_LSB +: 12]))
		else $error("memory bottom field not written");
	chk_mem_top_wr: assert property (@(posedge clk) disable iff (!rstn) // R15
		s_mem_write |=> mem_top_r == $past(wb_dat_i[bwss_pkg::MEM_TOP_LSB +: 12]))
		else $error("memory top field not written");
	chk_upper_wr: assert property (@(posedge clk) disable iff (!rstn) // R3
		s_upper_write |=> io_top_up_r == $past(wb_dat_i[31:16]))
		else $error("io upper top not written");
	// Each ungated event sets its flag
	chk_sta_set: assert property (@(posedge clk) disable iff (!rstn) // R8
		events.tx_ca_cpl |=> flags_r[1])
		else $error("completer abort sent flag not set");
	chk_rta_set: assert property (@(posedge clk) disable iff (!rstn) // R9
		events.rx_ca_cpl |=> flags_r[2])
		else $error("completer abort received flag not set");
	chk_rma_set: assert property (@(posedge clk) disable iff (!rstn) // R10
		events.rx_ur_cpl |=> flags_r[3])
		else $error("unsupported request flag not set");
	chk_pois_set: assert property (@(posedge clk) disable iff (!rstn) // R12
		events.poisoned_rx |=> flags_r[5])
		else $error("poison flag not set");
	// Read-only flags stay until reset
	chk_sta_sticky: assert property (@(posedge clk) disable iff (!rstn) // R8
		flags_r[1] |=> flags_r[1])
		else $error("completer abort sent flag lost");
	chk_rta_sticky: assert property (@(posedge clk) disable iff (!rstn) // R9
		flags_r[2] |=> flags_r[2])
		else $error("completer abort received flag lost");
	chk_rma_sticky: assert property (@(posedge clk) disable iff (!rstn) // R10
		flags_r[3] |=> flags_r[3])
		else $error("unsupported request flag lost");
	chk_ro_write: assert property (@(posedge clk) disable iff (!rstn) // R18
		s_status_write ##0 (flags_r[3:1] == 3'b000 && !events.tx_ca_cpl
			&& !events.rx_ca_cpl && !events.rx_ur_cpl) |=> flags_r[3:1] == 3'b000)
		else $error("write set a read-only flag");
	// Clears and set priority
	chk_par_clr: assert property (@(posedge clk) disable iff (!rstn) // R6 R18
		clr_v[0] && !set_v[0] |=> !flags_r[0])
		else $error("parity flag not cleared");
	chk_serr_clr: assert property (@(posedge clk) disable iff (!rstn) // R11 R18
		clr_v[4] && !set_v[4] |=> !flags_r[4])
		else $error("system error flag not cleared");
	chk_set_wins: assert property (@(posedge clk) disable iff (!rstn) // R18
		set_v[5] && clr_v[5] |=> flags_r[5])
		else $error("clear beat a same-cycle set");
	// Addresses outside a window never hit
	chk_io_below: assert property (@(posedge clk) disable iff (!rstn) // R16
		probe.addr < io_lo |=> !hits.io_hit)
		else $error("io hit below bottom");
	chk_io_above: assert property (@(posedge clk) disable iff (!rstn) // R4 R17
		probe.addr > io_hi |=> !hits.io_hit)
		else $error("io hit above top");
	chk_mem_below: assert property (@(posedge clk) disable iff (!rstn) // R14
		probe.addr < mem_lo |=> !hits.mem_hit)
		else $error("memory hit below bottom");
	chk_mem_above: assert property (@(posedge clk) disable iff (!rstn) // R15
		probe.addr > mem_hi |=> !hits.mem_hit)
		else $error("memory hit above top");
endmodule

// *** bwss_tb_top.sv ***
// Self-checking testbench for the bridge window and status register bank
`timescale 1ns/1ps
module bwss_tb_top;
	logic                     clk;          // 100 MHz clock
	logic                     rstn;         // Synchronous reset, active low
	logic                     cyc, stb, we; // Bus cycle controls
	logic [7:0]               adr;          // Bus byte address
	logic [3:0]               sel;          // Byte lanes
	logic [31:0]              dat_w, dat_r; // Bus data both ways
	logic                     ack, irq;     // Bus answer, interrupt
	bwss_pkg::bwss_event_type events;       // Error event pulses
	bwss_pkg::bwss_probe_type probe;        // Address under compare
	bwss_pkg::bwss_hit_type   hits;         // Window compare answer
	int                       miscompares, tests_run;
	logic [31:0]              rd;           // Scratch read data

	bwss_top dut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
		.events(events), .probe(probe), .hits(hits), .irq(irq));

	// Free-running clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Verdict in one place
	task automatic tally_and_finish();
		$display("Counts: %0d compares, %0d mismatches", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Word compare
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Single flag compare
	task automatic chk_bit(input logic got, input logic exp, input string what);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask

	// One classic cycle; held until ack is seen at a rising edge, then released
	task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q);
		int n;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dat_w <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		chk_bit(ack, 1'b1, "bus acknowledge");
		q = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		// Idle cycle between requests
		@(posedge clk);
	endtask

	task automatic wb_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		wb_xfer(1'b1, a, d, s, rd);
	endtask

	task automatic wb_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		wb_xfer(1'b0, a, 32'h0000_0000, 4'hf, rd);
		chk_word(rd, exp, what);
	endtask

	// Probe an address; hits are registered, so look two edges later
	task automatic probe_chk(input logic [31:0] a, input logic io_exp, input logic mem_exp);
		probe <= '{addr: a};
		repeat (2) @(posedge clk);
		chk_bit(hits.io_hit, io_exp, "io hit");
		chk_bit(hits.mem_hit, mem_exp, "mem hit");
	endtask

	// Reset values, read-only fields and an unmapped place
	task automatic test_reset_values();
		wb_rd(bwss_pkg::IO_STATUS_ADDR, 32'h0000_0100, "io/status reset");
		wb_rd(bwss_pkg::MEM_WINDOW_ADDR, 32'h0000_0000, "mem reset");
		wb_wr(8'h50, 32'hffff_ffff, 4'hf);
		wb_rd(8'h50, 32'h0000_0000, "unmapped read");
		wb_rd(bwss_pkg::IO_UPPER_ADDR, 32'h0000_0000, "upper reset");
		wb_rd(bwss_pkg::CONTROL_ADDR, 32'h0000_0000, "control reset");
		wb_rd(bwss_pkg::IRQ_MASK_ADDR, 32'h0000_0000, "mask reset");
	endtask

	// Reset in mid-run clears fields, flags and mask
	task automatic test_mid_reset();
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk_bit(irq, 1'b0, "irq after reset");
		wb_rd(bwss_pkg::IO_STATUS_ADDR, 32'h0000_0100, "status re-reset");
		wb_rd(bwss_pkg::MEM_WINDOW_ADDR, 32'h0000_0000, "mem re-reset");
		wb_rd(bwss_pkg::IRQ_MASK_ADDR, 32'h0000_0000, "mask re-reset");
	endtask

	// I/O window: writable fields, read-only bits, inclusive edges
	task automatic test_io_window();
		// Ones in the reserved bits and bits 25..29; only the writable fields may keep them
		wb_wr(bwss_pkg::IO_STATUS_ADDR, 32'h3eff_503f, 4'hf);
		wb_rd(bwss_pkg::IO_STATUS_ADDR, 32'h0000_5130, "io fields");
		wb_wr(bwss_pkg::IO_UPPER_ADDR, 32'h0002_0001, 4'hf);
		wb_rd(bwss_pkg::IO_UPPER_ADDR, 32'h0002_0001, "io upper");
		probe_chk(32'h0001_2fff, 1'b0, 1'b1);
		probe_chk(32'h0001_3000, 1'b1, 1'b1);
		probe_chk(32'h0002_5fff, 1'b1, 1'b1);
		probe_chk(32'h0002_6000, 1'b0, 1'b1);
	endtask

	// Memory window: lanes, reserved bits, inclusive edges
	task automatic test_mem_window();
		wb_wr(bwss_pkg::MEM_WINDOW_ADDR, 32'h005f_002f, 4'hf);
		wb_rd(bwss_pkg::MEM_WINDOW_ADDR, 32'h0050_0020, "mem fields");
		// Half a field selected must not update it
		wb_wr(bwss_pkg::MEM_WINDOW_ADDR, 32'h0070_0070, 4'h1);
		wb_rd(bwss_pkg::MEM_WINDOW_ADDR, 32'h0050_0020, "mem partial lanes");
		probe_chk(32'h001f_ffff, 1'b0, 1'b0);
		probe_chk(32'h0020_0000, 1'b0, 1'b1);
		probe_chk(32'h005f_ffff, 1'b0, 1'b1);
		probe_chk(32'h0060_0000, 1'b0, 1'b0);
	endtask

	// Error events, enables, interrupt mask and write-one-to-clear
	task automatic test_events();
		int flag_bit [6];
		flag_bit = '{24, 27, 28, 29, 30, 31};
		// Gated events with both enables off
		events <= 6'h11;
		@(posedge clk);
		events <= 6'h00;
		wb_rd(bwss_pkg::IO_STATUS_ADDR, 32'h0000_5130, "gated events");
		wb_wr(bwss_pkg::CONTROL_ADDR, 32'h0000_0003, 4'hf);
		wb_rd(bwss_pkg::CONTROL_ADDR, 32'h0000_0003, "control");
		// Each event alone sets its own flag; flags accumulate over the loop
		for (int i = 0; i < 6; i++) begin
			events <= 6'(1 << i);
			@(posedge clk);
			events <= 6'h00;
			wb_xfer(1'b0, bwss_pkg::IO_STATUS_ADDR, 32'h0000_0000, 4'hf, rd);
			chk_bit(rd[flag_bit[i]], 1'b1, "event flag");
		end
		chk_word(rd, 32'hf900_5130, "all flags");
		chk_bit(irq, 1'b0, "irq all masked");
		wb_wr(bwss_pkg::IRQ_MASK_ADDR, 32'h0100_0000, 4'hf);
		wb_rd(bwss_pkg::IRQ_MASK_ADDR, 32'h0100_0000, "mask layout");
		chk_bit(irq, 1'b1, "irq unmasked");
		// Clear parity only; zeros leave the rest
		wb_wr(bwss_pkg::IO_STATUS_ADDR, 32'h0100_5030, 4'hf);
		wb_rd(bwss_pkg::IO_STATUS_ADDR, 32'hf800_5130, "clear parity");
		chk_bit(irq, 1'b0, "irq after clear");
		// Ones to every flag: cleared ones go, read-only ones stay
		wb_wr(bwss_pkg::IO_STATUS_ADDR, 32'hf900_5030, 4'hf);
		wb_rd(bwss_pkg::IO_STATUS_ADDR, 32'h3800_5130, "clear all");
		// Poison event on the edge that takes its clear: the set wins
		events <= 6'h20;
		fork
			wb_wr(bwss_pkg::IO_STATUS_ADDR, 32'h8000_5030, 4'hf);
			begin
				@(posedge clk);
				events <= 6'h00;
			end
		join
		wb_rd(bwss_pkg::IO_STATUS_ADDR, 32'hb800_5130, "set beats clear");
	endtask

	// Main sequence
	initial begin
		rstn = 1'b0;
		{cyc, stb, we} = 3'b000;
		adr = 8'h00;
		sel = 4'h0;
		dat_w = 32'h0000_0000;
		events = 6'h00;
		probe = '{addr: 32'h0000_0000};
		miscompares = 0;
		tests_run = 0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		test_reset_values();
		test_io_window();
		test_mem_window();
		test_events();
		test_mid_reset();
		tally_and_finish();
	end

	// Watchdog well beyond the 140 or so cycles the tests need
	initial begin
		#50000;
		miscompares++;
		$display("Error at %0t: watchdog expired", $time);
		tally_and_finish();
	end
endmodule
